// >>> core/ucg_defs.svh
// Overview of operation
// - protected field write under unmet condition is ignored, old value kept
// - transmit stop length changes only while tx enable and tx busy are 0
// - parity, base clock, sample count change only with tx/rx enable and busy all 0
// - infrared select changes only while tx enable and tx busy are 0
// - noise filter and receive stop length change only while rx enable and busy are 0
// - low-power entry clears tx/rx enables; other control and divisor hold
// - low-power entry clears all status flags; data buffers undefined
// - idle or sleep: pin high when infrared off, low when on
// - stop mode: output-hold 1 gives idle level, 0 gives high impedance
// - frame starts with one low start bit then eight data bits
// - order: start, data lsb first, optional parity, stop bits
// - parity enable inserts parity bit; polarity selects even or odd
// - one or two stop bits per transmit stop length field
// - infrared select 1 sends frame in infrared pulse format
// - with two receive stop bits the first is not framing-checked
`ifndef UCG_DEFS_SVH
`define UCG_DEFS_SVH
`define UCG_OFF_CTRL1 8'h00
`define UCG_OFF_CTRL2 8'h04
`define UCG_OFF_STAT 8'h08
`define UCG_OFF_BAUD 8'h0C
`define UCG_OFF_DATA 8'h10
`define UCG_OFF_IRQ_STAT 8'h14
`define UCG_OFF_IRQ_MASK 8'h18
`define UCG_CR1_TXE 7
`define UCG_CR1_RXE 6
`define UCG_CR1_STOPBT 5
`define UCG_CR1_EVEN 4
`define UCG_CR1_PE 3
`define UCG_CR1_IRSEL 2
`define UCG_CR1_BRG 1
`define UCG_CR2_USED 8'h3F
`define UCG_SR_RBSY 3
`define UCG_SR_RECEIVE_FULL_FLAG 2
`define UCG_SR_TBSY 1
`define UCG_SR_TRANSMIT_FULL_FLAG 0
`define UCG_EV_TXDONE 0
`define UCG_EV_RXDONE 1
`define UCG_EV_ERR 2
`define UCG_RESP_OKAY 2'b00
`define UCG_RESP_SLVERR 2'b10
`define UCG_OVS 16
`define UCG_IR_PULSE 3
`endif

// >>> core/ucg_pkg.sv
package ucg_pkg;
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } ucg_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } ucg_axi_rsp_t;
   typedef enum logic [1:0] {
      UCG_RUN = 2'b00,
      UCG_IDLE = 2'b01,
      UCG_SLEEP = 2'b10,
      UCG_STOP = 2'b11
   } ucg_pmode_t;
   typedef enum logic [3:0] {
      UCG_TX_IDLE = 4'b0001,
      UCG_TX_SHIFT = 4'b0010,
      UCG_TX_PAR = 4'b0100,
      UCG_TX_STOP = 4'b1000
   } ucg_txst_t;
   typedef enum logic [3:0] {
      UCG_RX_IDLE = 4'b0001,
      UCG_RX_SHIFT = 4'b0010,
      UCG_RX_PAR = 4'b0100,
      UCG_RX_STOP = 4'b1000
   } ucg_rxst_t;
endpackage : ucg_pkg

// >>> core/ucg_uart.sv
`timescale 1ns/1ps
`include "ucg_defs.svh"
module ucg_uart (
   input wire logic ref_clk, // system clock 100 MHz
   input wire logic rstn, // async reset, active low
   input wire ucg_pkg::ucg_axi_req_t axi_req, // axi-lite master signals
   output ucg_pkg::ucg_axi_rsp_t axi_rsp, // axi-lite slave signals
   input wire ucg_pkg::ucg_pmode_t pmode, // low-power mode request
   input wire logic out_hold, // system output-hold bit
   input wire logic rx_in, // serial receive line
   output logic tx_out, // transmit pin level
   output logic tx_oe_n, // transmit pin enable, low drives
   output logic irq // level interrupt
);
   import ucg_pkg::*;
   typedef struct packed {
      logic [7:0] cr1;
      logic [7:0] cr2;
      logic [7:0] baud;
      logic parity_error_flag, framing_error_flag, overrun_error_flag, receive_full_flag, transmit_full_flag;
      logic [7:0] rxbuf, txbuf;
      logic [2:0] ist, imsk;
      ucg_txst_t txs;
      logic [7:0] tsh;
      logic [3:0] tbit;
      logic [7:0] tdiv;
      logic [4:0] tph;
      logic tpar, tline;
      ucg_rxst_t rxs;
      logic [7:0] rsh;
      logic [3:0] rbit;
      logic [7:0] rdiv;
      logic [4:0] rph;
      logic rpar;
      logic aw_h, w_h;
      logic [7:0] awa;
      logic [31:0] wd;
      logic bv;
      logic rv;
      logic [31:0] rd;
      ucg_pmode_t pm_prev;
   } ucg_state_t;
   ucg_state_t q, d;
   logic tbsy, rbsy, lp;
   logic [7:0] sr;
   function automatic logic tick(input logic [7:0] div, input logic [7:0] lim);
      tick = (div == lim);
   endfunction : tick
   // change windows of the protected fields, read before this cycle's write lands
   function automatic logic tx_quiet(input logic [7:0] cr1, input logic busy);
      tx_quiet = !cr1[`UCG_CR1_TXE] && !busy;
   endfunction : tx_quiet
   function automatic logic rx_quiet(input logic [7:0] cr1, input logic busy);
      rx_quiet = !cr1[`UCG_CR1_RXE] && !busy;
   endfunction : rx_quiet
   assign tbsy = (q.txs != UCG_TX_IDLE);
   assign rbsy = (q.rxs != UCG_RX_IDLE);
   assign lp = (pmode != UCG_RUN);
   assign sr = {q.parity_error_flag, q.framing_error_flag, q.overrun_error_flag, 1'b0, rbsy, q.receive_full_flag, tbsy, q.transmit_full_flag};
   always_comb begin
      logic wr, rd;
      logic [7:0] wb, nc1, nc2;
      logic txg, rxg;
      wr = 1'b0;
      rd = 1'b0;
      wb = 8'h00;
      nc1 = 8'h00;
      nc2 = 8'h00;
      txg = 1'b0;
      rxg = 1'b0;
      d = q;
      // axi-lite write path, address and data in either order
      if (axi_req.awvalid && !q.aw_h && !q.bv) begin
         d.aw_h = 1'b1;
         d.awa = axi_req.awaddr;
      end
      if (axi_req.wvalid && !q.w_h && !q.bv) begin
         d.w_h = 1'b1;
         d.wd = axi_req.wdata;
      end
      if (q.aw_h && q.w_h && !q.bv) begin
         wr = 1'b1;
         wb = q.wd[7:0];
         d.aw_h = 1'b0;
         d.w_h = 1'b0;
         d.bv = 1'b1;
      end
      if (q.bv && axi_req.bready) d.bv = 1'b0;
      if (axi_req.arvalid && !q.rv) begin
         rd = 1'b1;
         d.rv = 1'b1;
         d.rd = 32'h0000_0000;
         unique case (axi_req.araddr)
            `UCG_OFF_CTRL1: d.rd[7:0] = {q.cr1[7:1], 1'b0};
            `UCG_OFF_CTRL2: d.rd[7:0] = q.cr2 & `UCG_CR2_USED;
            `UCG_OFF_STAT: d.rd[7:0] = sr;
            `UCG_OFF_BAUD: d.rd[7:0] = q.baud;
            `UCG_OFF_DATA: begin
               d.rd[7:0] = q.rxbuf;
               d.receive_full_flag = 1'b0;
            end
            `UCG_OFF_IRQ_STAT: d.rd[2:0] = q.ist;
            `UCG_OFF_IRQ_MASK: d.rd[2:0] = q.imsk;
            default: d.rd = 32'h0000_0000;
         endcase
      end
      if (q.rv && axi_req.rready) d.rv = 1'b0;
      // register writes with change protection
      if (wr) begin
         unique case (q.awa)
            `UCG_OFF_CTRL1: begin
               nc1 = q.cr1;
               nc1[`UCG_CR1_TXE] = wb[`UCG_CR1_TXE];
               nc1[`UCG_CR1_RXE] = wb[`UCG_CR1_RXE];
               if (tx_quiet(q.cr1, tbsy)) begin
                  nc1[`UCG_CR1_STOPBT] = wb[`UCG_CR1_STOPBT];
                  nc1[`UCG_CR1_IRSEL] = wb[`UCG_CR1_IRSEL];
               end
               if (tx_quiet(q.cr1, tbsy) && rx_quiet(q.cr1, rbsy)) begin
                  nc1[`UCG_CR1_EVEN] = wb[`UCG_CR1_EVEN];
                  nc1[`UCG_CR1_PE] = wb[`UCG_CR1_PE];
                  nc1[`UCG_CR1_BRG] = wb[`UCG_CR1_BRG];
               end
               d.cr1 = nc1;
            end
            `UCG_OFF_CTRL2: begin
               nc2 = q.cr2;
               if (tx_quiet(q.cr1, tbsy) && rx_quiet(q.cr1, rbsy))
                  nc2[5:3] = wb[5:3];
               nc2[2] = wb[2];
               if (rx_quiet(q.cr1, rbsy))
                  nc2[1:0] = {wb[1], wb[0]};
               d.cr2 = nc2;
            end
            `UCG_OFF_BAUD: d.baud = wb;
            `UCG_OFF_DATA: begin
               d.txbuf = wb;
               d.transmit_full_flag = 1'b1;
            end
            `UCG_OFF_IRQ_MASK: d.imsk = wb[2:0];
            default: d.baud = d.baud;
         endcase
      end
      // read of interrupt status clears first, so events below still set: set wins
      if (rd && axi_req.araddr == `UCG_OFF_IRQ_STAT) d.ist = 3'b000;
      // transmitter, 16 phases per bit, phase counter ticks every baud+1 clocks
      d.tdiv = tick(q.tdiv, q.baud) ? 8'h00 : q.tdiv + 8'h01;
      if (q.txs != UCG_TX_IDLE && tick(q.tdiv, q.baud)) begin
         d.tph = q.tph + 5'd1;
         if (q.tph == 5'(`UCG_OVS - 1)) begin
            d.tph = 5'd0;
            txg = 1'b1;
         end
      end
      unique case (q.txs)
         UCG_TX_IDLE: begin
            d.tline = 1'b1;
            if (q.cr1[`UCG_CR1_TXE] && q.transmit_full_flag) begin
               d.txs = UCG_TX_SHIFT;
               d.tsh = q.txbuf;
               d.tpar = ^q.txbuf ^ ~q.cr1[`UCG_CR1_EVEN];
               // a buffer write landing now is kept for the next frame
               if (!(wr && q.awa == `UCG_OFF_DATA)) d.transmit_full_flag = 1'b0;
               d.tline = 1'b0;
               d.tbit = 4'd0;
               d.tph = 5'd0;
               d.tdiv = 8'h00;
            end
         end
         UCG_TX_SHIFT: if (txg) begin
            d.tbit = q.tbit + 4'd1;
            d.tline = q.tsh[0];
            d.tsh = {1'b0, q.tsh[7:1]};
            if (q.tbit == 4'd8) begin
               d.txs = q.cr1[`UCG_CR1_PE] ? UCG_TX_PAR : UCG_TX_STOP;
               d.tline = q.cr1[`UCG_CR1_PE] ? q.tpar : 1'b1;
               d.tbit = 4'd0;
            end
         end
         UCG_TX_PAR: if (txg) begin
            d.txs = UCG_TX_STOP;
            d.tline = 1'b1;
            d.tbit = 4'd0;
         end
         UCG_TX_STOP: if (txg) begin
            d.tbit = q.tbit + 4'd1;
            if (q.tbit == {3'd0, q.cr1[`UCG_CR1_STOPBT]}) begin
               d.txs = UCG_TX_IDLE;
               d.ist[`UCG_EV_TXDONE] = 1'b1;
            end
         end
      endcase
      // receiver, samples mid-bit
      d.rdiv = tick(q.rdiv, q.baud) ? 8'h00 : q.rdiv + 8'h01;
      if (q.rxs != UCG_RX_IDLE && tick(q.rdiv, q.baud)) begin
         d.rph = q.rph + 5'd1;
         if (q.rph == 5'(`UCG_OVS - 1)) d.rph = 5'd0;
         rxg = (q.rph == 5'(`UCG_OVS / 2 - 1));
      end
      unique case (q.rxs)
         UCG_RX_IDLE: if (q.cr1[`UCG_CR1_RXE] && !rx_in) begin
            d.rxs = UCG_RX_SHIFT;
            d.rbit = 4'd0;
            d.rph = 5'd0;
            d.rdiv = 8'h00;
         end
         UCG_RX_SHIFT: if (rxg) begin
            d.rbit = q.rbit + 4'd1;
            if (q.rbit == 4'd0 && rx_in) d.rxs = UCG_RX_IDLE;
            else if (q.rbit != 4'd0) d.rsh = {rx_in, q.rsh[7:1]};
            if (q.rbit == 4'd8) begin
               d.rpar = ^{rx_in, q.rsh[7:1]} ^ ~q.cr1[`UCG_CR1_EVEN];
               d.rxs = q.cr1[`UCG_CR1_PE] ? UCG_RX_PAR : UCG_RX_STOP;
               d.rbit = 4'd0;
            end
         end
         UCG_RX_PAR: if (rxg) begin
            d.parity_error_flag = q.parity_error_flag | (rx_in != q.rpar);
            d.rxs = UCG_RX_STOP;
         end
         UCG_RX_STOP: if (rxg) begin
            d.rbit = q.rbit + 4'd1;
            // first of two stop bits is skipped
            if (!(q.cr2[0] && q.rbit == 4'd0)) begin
               d.framing_error_flag = q.framing_error_flag | !rx_in;
               d.rxs = UCG_RX_IDLE;
               d.overrun_error_flag = q.overrun_error_flag | q.receive_full_flag;
               d.rxbuf = q.rsh;
               d.receive_full_flag = 1'b1;
               d.ist[`UCG_EV_RXDONE] = 1'b1;
               if (!rx_in || q.receive_full_flag) d.ist[`UCG_EV_ERR] = 1'b1;
            end
         end
      endcase
      // low-power entry halts the uart
      if (lp && q.pm_prev == UCG_RUN) begin
         d.cr1[`UCG_CR1_TXE] = 1'b0;
         d.cr1[`UCG_CR1_RXE] = 1'b0;
         {d.parity_error_flag, d.framing_error_flag, d.overrun_error_flag, d.receive_full_flag, d.transmit_full_flag} = 5'b0_0000;
         d.txs = UCG_TX_IDLE;
         d.rxs = UCG_RX_IDLE;
         d.tline = 1'b1;
      end
      d.pm_prev = pmode;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '{txs: UCG_TX_IDLE, rxs: UCG_RX_IDLE, pm_prev: UCG_RUN, tline: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end
   always_comb begin
      logic ir;
      ir = q.cr1[`UCG_CR1_IRSEL];
      tx_oe_n = 1'b0;
      if (pmode == UCG_IDLE || pmode == UCG_SLEEP) begin
         tx_out = !ir;
      end else if (pmode == UCG_STOP) begin
         tx_out = !ir;
         tx_oe_n = !out_hold;
      end else if (ir) begin
         // infrared: active-high pulse early in each zero bit
         tx_out = !q.tline && (q.tph < 5'd`UCG_IR_PULSE) && tbsy;
      end else begin
         tx_out = q.tline;
      end
   end
   assign irq = |(q.ist & q.imsk);
   assign axi_rsp.awready = !q.aw_h && !q.bv;
   assign axi_rsp.wready = !q.w_h && !q.bv;
   assign axi_rsp.bvalid = q.bv;
   assign axi_rsp.bresp = `UCG_RESP_OKAY;
   assign axi_rsp.arready = !q.rv;
   assign axi_rsp.rvalid = q.rv;
   assign axi_rsp.rdata = q.rd;
   assign axi_rsp.rresp = `UCG_RESP_OKAY;
endmodule : ucg_uart

// >>> verification/ucg_uart_chk.sv
`timescale 1ns/1ps
`include "ucg_defs.svh"
module ucg_uart_chk (
   input wire logic ref_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire ucg_pkg::ucg_axi_req_t axi_req, // bus requests
   input wire ucg_pkg::ucg_axi_rsp_t axi_rsp, // bus answers
   input wire ucg_pkg::ucg_pmode_t pmode, // power mode
   input wire logic out_hold, // output-hold bit
   input wire logic rx_in, // receive line
   input wire logic tx_out, // transmit level
   input wire logic tx_oe_n, // pin enable, low drives
   input wire logic irq // interrupt
);
   import ucg_pkg::*;
   wire bv = axi_rsp.bvalid;
   wire rv = axi_rsp.rvalid;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready ##1 !(axi_rsp.awready || axi_rsp.wready);
   endsequence
   a_stop_float: assert property (pmode == UCG_STOP && !out_hold |-> tx_oe_n)
      else $error("pin not released in stop mode");
   a_pin_driven: assert property (pmode != UCG_STOP || out_hold |-> !tx_oe_n)
      else $error("pin released outside stop mode");
   // a register write may move the idle level, so those cycles are left out
   a_lp_steady: assert property (pmode != UCG_RUN && pmode == $past(pmode) && !bv && !$past(bv) |-> $stable(tx_out))
      else $error("pin moved in low-power mode");
   a_wr_answer: assert property (s_wr_take |-> ##[0:2] bv)
      else $error("write response missing");
   a_wr_okay: assert property (bv |-> axi_rsp.bresp == `UCG_RESP_OKAY && !axi_rsp.awready && !axi_rsp.wready)
      else $error("write response not okay");
   a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> rv)
      else $error("read data late");
   a_rd_okay: assert property (rv |-> axi_rsp.rresp == `UCG_RESP_OKAY && axi_rsp.rdata[31:8] == 24'h000000)
      else $error("read response malformed");
   a_rd_stands: assert property (rv && !axi_req.rready |=> rv && $stable(axi_rsp.rdata))
      else $error("read data dropped early");
   a_b_release: assert property (bv && axi_req.bready |=> !bv)
      else $error("write response not retired");
   a_ar_blocked: assert property (rv |-> !axi_rsp.arready)
      else $error("read taken while answer pending");
endmodule : ucg_uart_chk
bind ucg_uart ucg_uart_chk ucg_uart_chk_i (.ref_clk(ref_clk), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .pmode(pmode), .out_hold(out_hold), .rx_in(rx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .irq(irq));

// >>> verification/ucg_remote.sv
`timescale 1ns/1ps
module ucg_remote #(
   parameter int BIT_CLKS = 32 // clocks per bit
) (
   input wire logic ref_clk, // system clock
   input wire logic tx_out, // device transmit pin
   output logic rx_in // device receive line
);
   logic [11:0] frame_q; // bit 0 holds the start bit
   initial begin
      rx_in = 1'b1;
      forever begin
         @(negedge tx_out);
         repeat (BIT_CLKS / 2) @(posedge ref_clk);
         for (int i = 0; i < 12; i++) begin
            frame_q[i] = tx_out;
            repeat (BIT_CLKS) @(posedge ref_clk);
         end
      end
   end
   // two stop bits; the first may be driven low on purpose
   task automatic send(input logic [7:0] b, input logic s1);
      logic [10:0] f;
      f = {1'b1, s1, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_in <= f[i];
         repeat (BIT_CLKS) @(posedge ref_clk);
      end
   endtask : send
endmodule : ucg_remote

// >>> verification/test_ucg_uart.sv
`timescale 1ns/1ps
`include "ucg_defs.svh"
module test_ucg_uart;
   import ucg_pkg::*;
   logic ref_clk;
   logic rstn;
   ucg_axi_req_t req;
   ucg_axi_rsp_t rsp;
   ucg_pmode_t pmode;
   logic out_hold;
   logic rx_in;
   logic tx_out;
   logic tx_oe_n;
   logic irq;
   int err_total;
   int num_checks;
   int ir_hi;
   wire pin = tx_oe_n ? 1'b1 : tx_out; // pulled up when released
   ucg_uart ucg_uart_i (.ref_clk(ref_clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .pmode(pmode),
      .out_hold(out_hold), .rx_in(rx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .irq(irq));
   ucg_remote #(.BIT_CLKS(32)) ucg_remote_i (.ref_clk(ref_clk), .tx_out(pin), .rx_in(rx_in));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      final_report();
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.awaddr <= a;
      req.wdata <= {24'h000000, d};
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (++n > 50) hang();
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (++n > 50) hang();
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      chk(rsp.rdata, exp);
   endtask : rc
   task automatic lp(input ucg_pmode_t m, input logic h);
      @(posedge ref_clk);
      pmode <= m;
      out_hold <= h;
      repeat (2) @(posedge ref_clk);
   endtask : lp
   initial begin
      err_total = 0;
      num_checks = 0;
      req = '0;
      pmode = UCG_RUN;
      out_hold = 1'b0;
      rstn = 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rc(8'h1C, 32'h0); // unmapped place reads zero
      wr(`UCG_OFF_CTRL1, 8'h80);
      wr(`UCG_OFF_CTRL1, 8'hBE);
      rc(`UCG_OFF_CTRL1, 32'h80);
      wr(`UCG_OFF_CTRL1, 8'h58);
      rc(`UCG_OFF_CTRL1, 32'h40);
      wr(`UCG_OFF_CTRL1, 8'h64);
      rc(`UCG_OFF_CTRL1, 32'h64);
      wr(`UCG_OFF_CTRL2, 8'h27);
      rc(`UCG_OFF_CTRL2, 32'h04);
      wr(`UCG_OFF_CTRL1, 8'h00);
      wr(`UCG_OFF_CTRL2, 8'h23);
      rc(`UCG_OFF_CTRL2, 32'h23);
      wr(`UCG_OFF_BAUD, 8'h01);
      $display("test protection done");
      wr(`UCG_OFF_CTRL1, 8'h40);
      ucg_remote_i.send(8'h3C, 1'b0);
      rc(`UCG_OFF_STAT, 32'h04);
      rc(`UCG_OFF_DATA, 32'h3C);
      chk(irq, 32'h0);
      rc(`UCG_OFF_IRQ_STAT, 32'h2);
      $display("test receive done");
      wr(`UCG_OFF_IRQ_MASK, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(`UCG_OFF_CTRL1, 8'h00);
         wr(`UCG_OFF_CTRL1, k ? 8'h08 : 8'h38);
         wr(`UCG_OFF_CTRL1, k ? 8'h88 : 8'hB8);
         wr(`UCG_OFF_DATA, 8'hA5);
         for (int n = 0; irq !== 1'b1; n++) begin
            @(posedge ref_clk);
            if (n > 2000) hang();
         end
         // let the partner finish sampling all twelve bit slots
         repeat (64) @(posedge ref_clk);
         chk(ucg_remote_i.frame_q, {20'h0, 2'b11, k[0], 8'hA5, 1'b0});
         rc(`UCG_OFF_IRQ_STAT, 32'h1);
         @(posedge ref_clk);
         chk(irq, 32'h0);
      end
      $display("test transmit done");
      wr(`UCG_OFF_DATA, 8'h5A);
      repeat (64) @(posedge ref_clk);
      lp(UCG_IDLE, 1'b0);
      chk(tx_out, 32'h1);
      rc(`UCG_OFF_STAT, 32'h0);
      rc(`UCG_OFF_CTRL1, 32'h08);
      rc(`UCG_OFF_BAUD, 32'h01);
      rc(`UCG_OFF_CTRL2, 32'h23);
      wr(`UCG_OFF_CTRL1, 8'h0C);
      lp(UCG_SLEEP, 1'b0);
      chk(tx_out, 32'h0);
      lp(UCG_STOP, 1'b0);
      chk(tx_oe_n, 32'h1);
      lp(UCG_STOP, 1'b1);
      chk({tx_oe_n, tx_out}, 32'h0);
      lp(UCG_RUN, 1'b0);
      wr(`UCG_OFF_CTRL1, 8'h8C);
      rc(`UCG_OFF_CTRL1, 32'h8C);
      $display("test low power done");
      ir_hi = 0;
      wr(`UCG_OFF_DATA, 8'hFE);
      for (int n = 0; irq !== 1'b1; n++) begin
         @(posedge ref_clk);
         if (tx_out === 1'b1) ir_hi++;
         if (n > 2000) hang();
      end
      // zero bits are start, bit 0 and odd parity; each pulse spans baud+1 clocks per phase
      chk(ir_hi, 3 * `UCG_IR_PULSE * 2);
      rc(`UCG_OFF_IRQ_STAT, 32'h1);
      $display("test infrared done");
      final_report();
   end
endmodule : test_ucg_uart
